// ### hdl/ube_pkg.sv
// package: constants for the usb upgrade boot-entry block
// assumes: single 200 MHz clock domain, classic wishbone register access
package ube_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_BOOT = 8'h0C;
  localparam logic [7:0] REG_SETUP_LO = 8'h10;
  localparam logic [7:0] REG_SETUP_HI = 8'h14;
  localparam logic [7:0] REG_REQ = 8'h18;
  localparam logic [7:0] REG_DESC = 8'h1C;
  localparam logic [7:0] REG_PLL = 8'h20;
  // ctrl fields
  localparam int CTRL_UPG_BIT = 0;
  localparam int CTRL_CFG_WE_BIT = 1;
  localparam int CTRL_BVEC_EN_BIT = 2;
  localparam int CTRL_X2_BIT = 3;
  localparam int CTRL_RESULT_LSB = 4;
  // cfg fields: port one, three, four patterns and boot vector
  localparam int CFG_PT1_LSB = 0;
  localparam int CFG_P3_LSB = 8;
  localparam int CFG_P4_LSB = 16;
  localparam int CFG_BVEC_LSB = 24;
  // reset values of the configuration bytes, then loader page and unused-pattern marker
  localparam logic [7:0] PT1_PATTERN_RST = 8'hFE;
  localparam logic [7:0] P3_PATTERN_RST = 8'hFF;
  localparam logic [7:0] P4_PATTERN_RST = 8'hFF;
  localparam logic [7:0] BVEC_RST = 8'hFC;
  localparam logic [7:0] LOADER_PAGE = 8'hFF;
  localparam logic [7:0] PATTERN_UNUSED = 8'hFF;
  // class request encoding
  localparam logic [7:0] RT_OUT = 8'h21;
  localparam logic [7:0] RT_IN = 8'hA1;
  localparam logic [7:0] RQ_DETACH = 8'h00;
  localparam logic [7:0] RQ_DNLOAD = 8'h01;
  localparam logic [7:0] RQ_UPLOAD = 8'h02;
  localparam logic [7:0] RQ_GETSTATUS = 8'h03;
  localparam logic [7:0] RQ_CLRSTATUS = 8'h04;
  localparam logic [7:0] RQ_GETSTATE = 8'h05;
  localparam logic [7:0] RQ_ABORT = 8'h06;
  localparam logic [15:0] LEN_STATUS = 16'h0006;
  localparam logic [15:0] LEN_STATE = 16'h0001;
  localparam logic [15:0] IFACE_NUM = 16'h0000;
  localparam logic [15:0] EP0_MAX = 16'h0020;
  // device descriptor
  localparam logic [7:0] DESC_LEN = 8'h12;
  localparam logic [7:0] DESC_TYPE = 8'h01;
  localparam logic [15:0] DESC_BCD_USB = 16'h0100;
  localparam logic [7:0] DESC_CLASS = 8'hFE;
  localparam logic [7:0] DESC_SUBCLASS = 8'h01;
  localparam logic [7:0] DESC_PROTOCOL = 8'h00;
  localparam logic [7:0] DESC_MAXPKT = 8'h20;
  localparam logic [15:0] DESC_BCD_DEV = 16'h0000;
  localparam logic [7:0] DESC_STR_IDX = 8'h00;
  localparam logic [7:0] DESC_NUM_CFG = 8'h01;
  // usb clock target in MHz
  localparam int USB_CLK_MHZ = 48;
  // pll multiplier/divider reset (48 MHz crystal, x1)
  localparam logic [7:0] PLL_RST = 8'h11;
  typedef enum logic [2:0] {
    UBE_RQ_DETACH,
    UBE_RQ_DNLOAD,
    UBE_RQ_UPLOAD,
    UBE_RQ_GETSTATUS,
    UBE_RQ_CLRSTATUS,
    UBE_RQ_GETSTATE,
    UBE_RQ_ABORT,
    UBE_RQ_NONE
  } ube_req_e;
endpackage : ube_pkg

// ### hdl/ube_req_decode.sv
// class request decoder for endpoint zero setup packets
// assumes: setup fields are stable while setup_valid is high
module ube_req_decode (
  input wire logic clk,
  input wire logic nrst,
  input wire logic setup_valid,
  input wire logic [7:0] req_type,
  input wire logic [7:0] req_code,
  input wire logic [15:0] req_value,
  input wire logic [15:0] req_index,
  input wire logic [15:0] req_length,
  output ube_pkg::ube_req_e req_kind,
  output logic req_stall,
  output logic req_done
);
  ube_pkg::ube_req_e kind_nxt;
  logic ok_nxt;

  always_comb begin
    kind_nxt = ube_pkg::UBE_RQ_NONE;
    ok_nxt = 1'b0;
    if (req_index == ube_pkg::IFACE_NUM) begin
      case (req_code)
        ube_pkg::RQ_DETACH: begin
          kind_nxt = ube_pkg::UBE_RQ_DETACH;
          ok_nxt = (req_type == ube_pkg::RT_OUT) && (req_length == 16'h0000);
        end
        ube_pkg::RQ_DNLOAD: begin
          kind_nxt = ube_pkg::UBE_RQ_DNLOAD;
          ok_nxt = (req_type == ube_pkg::RT_OUT);
        end
        ube_pkg::RQ_UPLOAD: begin
          kind_nxt = ube_pkg::UBE_RQ_UPLOAD;
          ok_nxt = (req_type == ube_pkg::RT_IN);
        end
        ube_pkg::RQ_GETSTATUS: begin
          kind_nxt = ube_pkg::UBE_RQ_GETSTATUS;
          ok_nxt = (req_type == ube_pkg::RT_IN) && (req_value == 16'h0000)
            && (req_length == ube_pkg::LEN_STATUS);
        end
        ube_pkg::RQ_CLRSTATUS: begin
          kind_nxt = ube_pkg::UBE_RQ_CLRSTATUS;
          ok_nxt = (req_type == ube_pkg::RT_OUT) && (req_value == 16'h0000)
            && (req_length == 16'h0000);
        end
        ube_pkg::RQ_GETSTATE: begin
          kind_nxt = ube_pkg::UBE_RQ_GETSTATE;
          ok_nxt = (req_type == ube_pkg::RT_IN) && (req_value == 16'h0000)
            && (req_length == ube_pkg::LEN_STATE);
        end
        ube_pkg::RQ_ABORT: begin
          kind_nxt = ube_pkg::UBE_RQ_ABORT;
          ok_nxt = (req_type == ube_pkg::RT_OUT) && (req_value == 16'h0000)
            && (req_length == 16'h0000);
        end
        default: begin
          kind_nxt = ube_pkg::UBE_RQ_NONE;
          ok_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      req_kind <= ube_pkg::UBE_RQ_NONE;
      req_stall <= 1'b0;
      req_done <= 1'b0;
    end else begin
      req_done <= setup_valid;
      req_stall <= setup_valid && !ok_nxt;
      if (setup_valid) begin
        req_kind <= ok_nxt ? kind_nxt : ube_pkg::UBE_RQ_NONE;
      end
    end
  end
endmodule : ube_req_decode

// ### hdl/ube_boot_entry.sv
// top: boot-entry selection, usb clock setup and upgrade request front end
// assumes: pins are asynchronous, the usb engine hands over setup packets
//   on the same clock, software reaches registers over classic wishbone
// Operation
// - high pin count: access strap high and store pin low force the loader.
// - straps are sampled only at reset release, ignored afterwards.
// - low pin count: loader entered when first port reads FEh.
// - user patterns on port one, three, or port four bits 0-1, in priority; nrst resets them before the one sample, so only FEh on port one hits.
// - pattern bytes are writable by software or by a usb command, both only in upgrade mode.
// - loader restart only when the loader jump fuse is 0.
// - software boot vector set boots user loader at vector times 100h.
// - upgrade traffic uses endpoint zero only, 32-byte packets.
// - pll makes 48 MHz from 6 to 48 MHz crystals, x1 or x2 mode.
// - run-time activity halts in upgrade mode; entry needs outside trigger.
// - seven class requests to interface 0 decoded with their request types.
// - getstatus 6 bytes, getstate 1 byte, detach/clr/abort no data.
// - upgrade mode exports one device, config, interface, functional desc; only the device descriptor is built here.
// - device descriptor served only in upgrade mode, class FEh/01h/00h.
// - descriptor 12h long, usb 0100h, ep0 size 32, string indices 0.
// - one configuration, release 0000h, 16-bit vendor and product ids.
// - getstatus reports the result of the most recent request.
//
// Chosen here: the Wishbone interface to the registers and the register addresses.
module ube_boot_entry #(
  parameter logic [15:0] VENDOR_ID = 16'h1234, // arbitrary value
  parameter logic [15:0] PRODUCT_ID = 16'h5678, // arbitrary value
  parameter bit HIGH_PIN_COUNT = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // pins
  input wire logic external_access_strap,
  input wire logic program_store_strobe_pin_i,
  output logic program_store_strobe_pin_o,
  output logic program_store_strobe_pin_oe_n,
  input wire logic [7:0] first_io_port,
  input wire logic [7:0] third_io_port,
  input wire logic [1:0] fourth_io_port,
  input wire logic loader_jump_fuse,
  // usb engine side
  input wire logic setup_valid,
  input wire logic [7:0] setup_type,
  input wire logic [7:0] setup_code,
  input wire logic [15:0] setup_value,
  input wire logic [15:0] setup_index,
  input wire logic [15:0] setup_length,
  input wire logic [3:0] setup_endpoint,
  input wire logic [4:0] desc_index,
  output logic [7:0] desc_byte,
  output logic ep0_stall,
  output logic [2:0] req_kind_o,
  output logic req_pulse,
  // boot and clock outputs
  output logic loader_select,
  output logic [15:0] boot_address,
  output logic app_halt,
  output logic [7:0] pll_ratio
);
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic ext_m_r, ext_s_r, ps_m_r, ps_s_r;
  logic [7:0] pt1_m_r, pt1_s_r, p3_m_r, p3_s_r;
  logic [1:0] p4_m_r, p4_s_r;
  logic fuse_m_r, fuse_s_r;

  always_ff @(posedge clk) begin
    ext_m_r <= external_access_strap;
    ext_s_r <= ext_m_r;
    ps_m_r <= program_store_strobe_pin_i;
    ps_s_r <= ps_m_r;
    pt1_m_r <= first_io_port;
    pt1_s_r <= pt1_m_r;
    p3_m_r <= third_io_port;
    p3_s_r <= p3_m_r;
    p4_m_r <= fourth_io_port;
    p4_s_r <= p4_m_r;
    fuse_m_r <= loader_jump_fuse;
    fuse_s_r <= fuse_m_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] pt1_pat_r, p3_pat_r, p4_pat_r, bvec_r, pll_r;
  logic upg_r, bvec_en_r, x2_r, cfg_we_usb;
  logic [3:0] result_r;
  logic [7:0] cfg_byte_usb;
  logic [1:0] cfg_sel_usb;
  logic ack_r;
  logic wr_hit;
  logic req_pulse_nxt, stall_w, len_stall;
  ube_pkg::ube_req_e kind_w;
  logic [15:0] setup_value_r, setup_length_r;

  assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;

  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] d,
                                            input logic [3:0] sel, input int lane);
    merge_byte = sel[lane] ? d[lane*8 +: 8] : old;
  endfunction : merge_byte

  // usb path: dnload with wvalue FFxx rewrites a pattern or boot vector byte (xx low 2 bits pick it)
  assign cfg_we_usb = req_pulse_nxt && (kind_w == ube_pkg::UBE_RQ_DNLOAD)
    && (setup_value_r[15:8] == 8'hFF);
  assign cfg_sel_usb = setup_value_r[1:0];
  assign cfg_byte_usb = setup_length_r[7:0];
  assign len_stall = req_pulse_nxt && (kind_w == ube_pkg::UBE_RQ_DNLOAD)
    && (setup_length_r > ube_pkg::EP0_MAX) && !cfg_we_usb;

  // pattern bytes, writable from bus or usb command, both only while upg_r is set
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pt1_pat_r <= ube_pkg::PT1_PATTERN_RST;
      p3_pat_r <= ube_pkg::P3_PATTERN_RST;
      p4_pat_r <= ube_pkg::P4_PATTERN_RST;
      bvec_r <= ube_pkg::BVEC_RST;
    end else if (wr_hit && wb_adr_i == ube_pkg::REG_CFG && upg_r) begin
      pt1_pat_r <= merge_byte(pt1_pat_r, wb_dat_i, wb_sel_i, 0);
      p3_pat_r <= merge_byte(p3_pat_r, wb_dat_i, wb_sel_i, 1);
      p4_pat_r <= merge_byte(p4_pat_r, wb_dat_i, wb_sel_i, 2);
      bvec_r <= merge_byte(bvec_r, wb_dat_i, wb_sel_i, 3);
    end else if (cfg_we_usb) begin
      case (cfg_sel_usb)
        2'd0: pt1_pat_r <= cfg_byte_usb;
        2'd1: p3_pat_r <= cfg_byte_usb;
        2'd2: p4_pat_r <= cfg_byte_usb;
        default: bvec_r <= cfg_byte_usb;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      bvec_en_r <= 1'b0;
      x2_r <= 1'b0;
      pll_r <= ube_pkg::PLL_RST;
    end else if (wr_hit && wb_adr_i == ube_pkg::REG_CTRL && wb_sel_i[0]) begin
      bvec_en_r <= wb_dat_i[ube_pkg::CTRL_BVEC_EN_BIT];
      x2_r <= wb_dat_i[ube_pkg::CTRL_X2_BIT];
    end else if (wr_hit && wb_adr_i == ube_pkg::REG_PLL && wb_sel_i[0]) begin
      pll_r <= wb_dat_i[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // strap capture at reset release
  logic rst_seen_r, captured_r, strap_hit_r;
  logic pt1_hit, p3_hit, p4_hit, pattern_hit;

  // fixed priority: port one, then three, then four
  assign pt1_hit = (pt1_pat_r != ube_pkg::PATTERN_UNUSED) && (pt1_s_r == pt1_pat_r);
  assign p3_hit = (p3_pat_r != ube_pkg::PATTERN_UNUSED) && (p3_s_r == p3_pat_r);
  assign p4_hit = (p4_pat_r != ube_pkg::PATTERN_UNUSED) && (p4_s_r == p4_pat_r[1:0]);
  assign pattern_hit = pt1_hit ? 1'b1 : (p3_hit ? 1'b1 : p4_hit);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rst_seen_r <= 1'b0;
      captured_r <= 1'b0;
      strap_hit_r <= 1'b0;
    end else begin
      // wait out the two synchroniser stages, then sample once
      rst_seen_r <= 1'b1;
      if (rst_seen_r && !captured_r) begin
        captured_r <= 1'b1;
        if (HIGH_PIN_COUNT) begin
          strap_hit_r <= ext_s_r && !ps_s_r;
        end else begin
          strap_hit_r <= pattern_hit;
        end
      end
    end
  end

  // loader mode: strap, or software request with the jump fuse programmed
  always_ff @(posedge clk) begin
    if (!nrst) begin
      upg_r <= 1'b0;
    end else if (rst_seen_r && !captured_r) begin
      upg_r <= HIGH_PIN_COUNT ? (ext_s_r && !ps_s_r) : pattern_hit;
    end else if (wr_hit && wb_adr_i == ube_pkg::REG_CTRL && wb_sel_i[0]
                 && wb_dat_i[ube_pkg::CTRL_UPG_BIT]) begin
      upg_r <= upg_r || !fuse_s_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      loader_select <= 1'b0;
      boot_address <= 16'h0000;
      app_halt <= 1'b0;
      pll_ratio <= ube_pkg::PLL_RST;
      program_store_strobe_pin_o <= 1'b1;
      program_store_strobe_pin_oe_n <= 1'b1;
    end else begin
      loader_select <= upg_r;
      app_halt <= upg_r;
      if (upg_r) begin
        boot_address <= {ube_pkg::LOADER_PAGE, 8'h00};
      end else if (bvec_en_r) begin
        boot_address <= {bvec_r, 8'h00};
      end else begin
        boot_address <= 16'h0000;
      end
      // x2 halves the whole pll_r byte so the output stays at 48 MHz
      pll_ratio <= x2_r ? {1'b0, pll_r[7:1]} : pll_r;
      // drive the store pin only once the strap has been taken
      program_store_strobe_pin_oe_n <= !captured_r;
      program_store_strobe_pin_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // endpoint zero class requests
  logic setup_ep0;
  logic [31:0] setup_lo_r;

  assign setup_ep0 = setup_valid && (setup_endpoint == 4'h0);

  ube_req_decode u_dec (
    .clk(clk),
    .nrst(nrst),
    .setup_valid(setup_ep0 && upg_r),
    .req_type(setup_type),
    .req_code(setup_code),
    .req_value(setup_value),
    .req_index(setup_index),
    .req_length(setup_length),
    .req_kind(kind_w),
    .req_stall(stall_w),
    .req_done(req_pulse_nxt)
  );

  always_ff @(posedge clk) begin
    if (!nrst) begin
      setup_value_r <= 16'h0000;
      setup_length_r <= 16'h0000;
      setup_lo_r <= 32'h0000_0000;
    end else if (setup_ep0) begin
      setup_value_r <= setup_value;
      setup_length_r <= setup_length;
      setup_lo_r <= {setup_value, setup_code, setup_type};
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ep0_stall <= 1'b0;
      req_pulse <= 1'b0;
      req_kind_o <= 3'h7;
      result_r <= 4'h0;
    end else begin
      ep0_stall <= stall_w || len_stall;
      req_pulse <= req_pulse_nxt && !stall_w && !len_stall;
      req_kind_o <= kind_w;
      if (req_pulse_nxt) begin
        // 0 ok, 1 failed, status query keeps last result
        if (stall_w || len_stall) begin
          result_r <= 4'h1;
        end else if (kind_w == ube_pkg::UBE_RQ_CLRSTATUS) begin
          result_r <= 4'h0;
        end else if (kind_w != ube_pkg::UBE_RQ_GETSTATUS) begin
          result_r <= 4'h0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // device descriptor rom, present only in upgrade mode
  always_ff @(posedge clk) begin
    if (!nrst) begin
      desc_byte <= 8'h00;
    end else if (!upg_r) begin
      desc_byte <= 8'h00;
    end else begin
      case (desc_index)
        5'd0: desc_byte <= ube_pkg::DESC_LEN;
        5'd1: desc_byte <= ube_pkg::DESC_TYPE;
        5'd2: desc_byte <= ube_pkg::DESC_BCD_USB[7:0];
        5'd3: desc_byte <= ube_pkg::DESC_BCD_USB[15:8];
        5'd4: desc_byte <= ube_pkg::DESC_CLASS;
        5'd5: desc_byte <= ube_pkg::DESC_SUBCLASS;
        5'd6: desc_byte <= ube_pkg::DESC_PROTOCOL;
        5'd7: desc_byte <= ube_pkg::DESC_MAXPKT;
        5'd8: desc_byte <= VENDOR_ID[7:0];
        5'd9: desc_byte <= VENDOR_ID[15:8];
        5'd10: desc_byte <= PRODUCT_ID[7:0];
        5'd11: desc_byte <= PRODUCT_ID[15:8];
        5'd12: desc_byte <= ube_pkg::DESC_BCD_DEV[7:0];
        5'd13: desc_byte <= ube_pkg::DESC_BCD_DEV[15:8];
        5'd14, 5'd15, 5'd16: desc_byte <= ube_pkg::DESC_STR_IDX;
        5'd17: desc_byte <= ube_pkg::DESC_NUM_CFG;
        default: desc_byte <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wishbone read and ack: one wait state, ack drops the cycle after
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ack_r <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
      wb_ack_o <= wb_cyc_i && wb_stb_i && !ack_r;
      case (wb_adr_i)
        ube_pkg::REG_CTRL: wb_dat_o <= {24'h0, result_r, x2_r, bvec_en_r, upg_r, upg_r};
        ube_pkg::REG_CFG: wb_dat_o <= {bvec_r, p4_pat_r, p3_pat_r, pt1_pat_r};
        ube_pkg::REG_STATUS: wb_dat_o <= {28'h0, fuse_s_r, strap_hit_r, captured_r, upg_r};
        ube_pkg::REG_BOOT: wb_dat_o <= {16'h0, boot_address};
        ube_pkg::REG_SETUP_LO: wb_dat_o <= setup_lo_r;
        ube_pkg::REG_SETUP_HI: wb_dat_o <= {setup_length_r, 16'h0};
        ube_pkg::REG_REQ: wb_dat_o <= {28'h0, ep0_stall, req_kind_o};
        ube_pkg::REG_PLL: wb_dat_o <= {24'h0, pll_r};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end
endmodule : ube_boot_entry

// ### bench/ube_assertions.sv
// checker: port-level timing of the boot-entry top
// assumes: bound to ube_boot_entry; app_halt high marks upgrade mode
module ube_assertions (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic setup_valid,
  input wire logic [7:0] setup_type,
  input wire logic [7:0] setup_code,
  input wire logic [15:0] setup_index,
  input wire logic [15:0] setup_length,
  input wire logic [3:0] setup_endpoint,
  input wire logic [7:0] desc_byte,
  input wire logic ep0_stall,
  input wire logic [2:0] req_kind_o,
  input wire logic req_pulse,
  input wire logic app_halt,
  input wire logic [7:0] pll_ratio
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  logic ep0_up;
  assign ep0_up = setup_valid && setup_endpoint == 4'h0 && app_halt && setup_index == 16'h0000;
  ////////////////////////////////////////////////////////////////////////////////
  property p_ack_one;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack not one cycle after request");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_stall_pulse;
    ep0_stall |=> !ep0_stall;
  endproperty
  a_stall_pulse: assert property (p_stall_pulse) else $error("stall longer than one cycle");
  property p_excl;
    !(ep0_stall && req_pulse);
  endproperty
  a_excl: assert property (p_excl) else $error("stall and accept together");
  property p_non_ep0;
    setup_valid && setup_endpoint != 4'h0 |-> ##2 !req_pulse && !ep0_stall;
  endproperty
  a_non_ep0: assert property (p_non_ep0) else $error("other endpoint answered");
  property p_getstatus;
    ep0_up && setup_type == 8'hA1 && setup_code == 8'h03 && setup_length == 16'h0006
      |-> ##2 req_pulse && req_kind_o == 3'h3;
  endproperty
  a_getstatus: assert property (p_getstatus) else $error("status request not accepted");
  property p_bad_type;
    ep0_up && setup_type == 8'h21 && setup_code == 8'h03 |-> ##2 ep0_stall;
  endproperty
  a_bad_type: assert property (p_bad_type) else $error("wrong type not stalled");
  property p_desc_zero;
    !app_halt [*3] |-> desc_byte == 8'h00;
  endproperty
  a_desc_zero: assert property (p_desc_zero) else $error("descriptor outside upgrade");
  property p_pll_reset;
    $rose(nrst) |-> pll_ratio == 8'h11;
  endproperty
  a_pll_reset: assert property (p_pll_reset) else $error("pll ratio reset value");
endmodule : ube_assertions
bind ube_boot_entry ube_assertions u_ube_chk (.clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .setup_valid, .setup_type, .setup_code, .setup_index, .setup_length, .setup_endpoint,
  .desc_byte, .ep0_stall, .req_kind_o, .req_pulse, .app_halt, .pll_ratio);

// ### bench/ube_usb_host.sv
// partner: usb host handing class setup packets to the block
// assumes: shared clock; answer lands one edge after the taking edge
module ube_usb_host (
  input wire logic clk,
  input wire logic ep0_stall,
  input wire logic req_pulse,
  input wire logic [2:0] req_kind_o,
  output logic setup_valid,
  output logic [7:0] setup_type,
  output logic [7:0] setup_code,
  output logic [15:0] setup_value,
  output logic [15:0] setup_index,
  output logic [15:0] setup_length,
  output logic [3:0] setup_endpoint
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    setup_valid = 1'b0;
    {setup_type, setup_code, setup_value, setup_index, setup_length} = '0;
    setup_endpoint = 4'h0;
  end
  // fields go stale once valid drops, so they are inverted then
  task automatic send(input logic [7:0] t, c, input logic [15:0] v, i, l,
      input logic [3:0] ep, output logic st, pk, output logic [2:0] kd);
    @(posedge clk);
    setup_valid <= 1'b1;
    setup_type <= t;
    setup_code <= c;
    setup_value <= v;
    setup_index <= i;
    setup_length <= l;
    setup_endpoint <= ep;
    @(posedge clk);
    setup_valid <= 1'b0;
    {setup_type, setup_code, setup_value, setup_index, setup_length} <= ~{t, c, v, i, l};
    repeat (1) @(posedge clk);
    #1;
    st = ep0_stall;
    pk = req_pulse;
    kd = req_kind_o;
  endtask : send
endmodule : ube_usb_host

// ### bench/testbench.sv
// testbench: strap entry, descriptor, registers and class requests of the top
// assumes: high pin count build, loader fuse programmed, host model on setup side
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] VID = 16'hA55A; // arbitrary value
  localparam logic [15:0] PID = 16'h3C3C; // arbitrary value
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, ext, pso_o, pso_oe_n, pso_pin, ep0_stall, req_pulse, loader_select, app_halt;
  logic [4:0] desc_index = 5'h00;
  logic [7:0] desc_byte, pll_ratio, setup_type, setup_code;
  logic [2:0] req_kind_o;
  logic [15:0] boot_address, setup_value, setup_index, setup_length;
  logic setup_valid;
  logic [3:0] setup_endpoint;
  int mismatches = 0;
  int num_checks = 0;
  initial ext = 1'b1;
  always #2.5 clk = ~clk;
  // store pin pulled down whenever the block leaves it
  assign pso_pin = !pso_oe_n ? pso_o : 1'b0;
  ube_boot_entry #(.VENDOR_ID(VID), .PRODUCT_ID(PID), .HIGH_PIN_COUNT(1'b1)) dut (.clk, .nrst,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .external_access_strap(ext), .program_store_strobe_pin_i(pso_pin),
    .program_store_strobe_pin_o(pso_o), .program_store_strobe_pin_oe_n(pso_oe_n),
    .first_io_port(8'hFF), .third_io_port(8'hFF), .fourth_io_port(2'h3),
    .loader_jump_fuse(1'b0), .setup_valid, .setup_type, .setup_code, .setup_value,
    .setup_index, .setup_length, .setup_endpoint, .desc_index, .desc_byte, .ep0_stall,
    .req_kind_o, .req_pulse, .loader_select, .boot_address, .app_halt, .pll_ratio);
  ube_usb_host host (.clk, .ep0_stall, .req_pulse, .req_kind_o, .setup_valid, .setup_type,
    .setup_code, .setup_value, .setup_index, .setup_length, .setup_endpoint);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wb(input logic [7:0] a, input logic we, input logic [3:0] s,
      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    chk(n < 20, 1'b1, "wb ack");
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic req(input logic [7:0] t, c, input logic [15:0] v, i, l, input logic [3:0] ep,
      input logic est, epk, input logic [2:0] ekd, input string what);
    logic st, pk;
    logic [2:0] kd;
    host.send(t, c, v, i, l, ep, st, pk, kd);
    chk(st, est, what);
    chk(pk, epk, what);
    if (epk) chk(kd, ekd, what);
  endtask : req
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_strap;
    repeat (4) @(posedge clk);
    ext <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk(loader_select, 1'b1, "loader entry held");
    chk(boot_address, 16'hFF00, "loader boot address");
    chk(app_halt, 1'b1, "run-time halted");
    chk(pso_oe_n, 1'b0, "store pin driven");
    chk(pso_o, 1'b1, "store pin level");
    $display("test strap done");
  endtask : test_strap
  task automatic test_desc;
    logic [7:0] e [18];
    e = '{8'h12, 8'h01, 8'h00, 8'h01, 8'hFE, 8'h01, 8'h00, 8'h20, VID[7:0], VID[15:8],
      PID[7:0], PID[15:8], 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
    for (int k = 0; k < 18; k++) begin
      @(posedge clk);
      desc_index <= 5'(k);
      repeat (2) @(posedge clk);
      #1;
      chk(desc_byte, e[k], "descriptor byte");
    end
    $display("test desc done");
  endtask : test_desc
  task automatic test_cfg;
    logic [31:0] q;
    wb(ube_pkg::REG_CFG, 1'b1, 4'h1, 32'h0000_00AB, q);
    wb(ube_pkg::REG_CFG, 1'b0, 4'hF, 32'h0, q);
    chk(q[7:0], 8'hAB, "cfg write by software");
    req(8'h21, 8'h01, 16'hFF01, 16'h0, 16'h00A5, 4'h0, 1'b0, 1'b1, 3'h1, "cfg dnload");
    wb(ube_pkg::REG_CFG, 1'b0, 4'hF, 32'h0, q);
    chk(q[15:8], 8'hA5, "cfg write by usb");
    wb(ube_pkg::REG_PLL, 1'b0, 4'hF, 32'h0, q);
    chk(q[7:0], 8'h11, "pll reset value");
    chk(pll_ratio, 8'h11, "pll ratio port");
    wb(ube_pkg::REG_STATUS, 1'b0, 4'hF, 32'h0, q);
    chk(q[3:0], 4'h7, "strap status");
    wb(8'h40, 1'b0, 4'hF, 32'h0, q);
    chk(q, 32'h0, "unmapped read");
    $display("test cfg done");
  endtask : test_cfg
  task automatic test_stall;
    logic [31:0] q;
    req(8'h21, 8'h03, 16'h0, 16'h0, 16'h0006, 4'h0, 1'b1, 1'b0, 3'h0, "type");
    req(8'hA1, 8'h03, 16'h0, 16'h0, 16'h0005, 4'h0, 1'b1, 1'b0, 3'h0, "length");
    req(8'hA1, 8'h05, 16'h0, 16'h1, 16'h0001, 4'h0, 1'b1, 1'b0, 3'h0, "index");
    req(8'h21, 8'h07, 16'h0, 16'h0, 16'h0000, 4'h0, 1'b1, 1'b0, 3'h0, "code");
    req(8'h21, 8'h01, 16'h0, 16'h0, 16'h0021, 4'h0, 1'b1, 1'b0, 3'h0, "long");
    req(8'hA1, 8'h03, 16'h0, 16'h0, 16'h0006, 4'h1, 1'b0, 1'b0, 3'h0, "endpoint");
    wb(ube_pkg::REG_CTRL, 1'b0, 4'h1, 32'h0, q);
    chk(q[7:4], 4'h1, "result after stall");
    req(8'h21, 8'h04, 16'h0, 16'h0, 16'h0000, 4'h0, 1'b0, 1'b1, 3'h4, "clear");
    wb(ube_pkg::REG_CTRL, 1'b0, 4'h1, 32'h0, q);
    chk(q[7:4], 4'h0, "result after accept");
    $display("test stall done");
  endtask : test_stall
  task automatic test_requests;
    logic [7:0] rt [7];
    logic [15:0] ln [7];
    rt = '{8'h21, 8'h21, 8'hA1, 8'hA1, 8'h21, 8'hA1, 8'h21};
    ln = '{16'h0, 16'h0020, 16'h0020, 16'h0006, 16'h0, 16'h0001, 16'h0};
    for (int k = 6; k >= 0; k--) begin
      req(rt[k], 8'(k), 16'h0, 16'h0, ln[k], 4'h0, 1'b0, 1'b1, 3'(k), "request");
    end
    $display("test requests done");
  endtask : test_requests
  initial begin
    #40000;
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out();
  end
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    test_strap();
    test_desc();
    test_cfg();
    test_stall();
    test_requests();
    close_out();
  end
endmodule : testbench
